/* ofm_acc_read.sv */
// Accumulator source path: scaling shifter and saturation limiter.
// Purely combinational; the parent registers whatever it drives out.
`timescale 1ns/100ps
module ofm_acc_read (
  input wire logic [55:0] acc_in, // Full accumulator
  input wire logic [1:0] scale_in, // Scaling mode
  input wire logic six_in, // Sixteen-bit mode
  output logic [23:0] word_out, // Limited 24-bit word
  output logic lim_out // Limiting applied
);
  wire logic [55:0] shifted;
  wire logic [23:0] mid;
  wire logic [23:0] sat;
  assign shifted = (scale_in == ofm_pkg::SCALE_DOWN) ? {acc_in[55], acc_in[55:1]} :
                   (scale_in == ofm_pkg::SCALE_UP) ? {acc_in[54:0], 1'b0} : acc_in;
  // Extension in use when bits 55..47 are not all copies of the sign
  assign lim_out = (|shifted[55:47]) & ~(&shifted[55:47]);
  assign sat = shifted[55] ? ofm_pkg::SAT_NEG : ofm_pkg::SAT_POS;
  assign mid = shifted[47:24];
  assign word_out = lim_out ? sat : (six_in ? {mid[23:8], 8'h00} : mid);
endmodule

/* ofm_acc_write.sv */
// Accumulator destination formatting: sign extension and zero fill.
// Combinational; the parent decides which registers take the result.
`timescale 1ns/100ps
module ofm_acc_write (
  input wire logic [23:0] src_in, // 24-bit source word
  input wire logic six_in, // Sixteen-bit mode
  output ofm_pkg::ofm_acc_s acc_out // Formatted accumulator parts
);
  assign acc_out.ext = {8{src_in[23]}};
  assign acc_out.mid = six_in ? {src_in[23:8], 8'h00} : src_in;
  assign acc_out.low = 24'h000000;
endmodule

/* ofm_mem_model.sv */
// Program memory and X/Y data memories facing the operand move datapath.
// Each answers a read strobe one cycle later; released lines show inverted data.
`timescale 1ns/100ps
module ofm_mem_model (
  input wire logic ref_clk_in, // Core clock
  input wire logic pm_rd_in, // Program read strobe
  input wire logic [23:0] pm_addr_in, // Program address
  output logic [23:0] pm_data_out, // Program word
  input ofm_pkg::ofm_bus_s x_bus_in, // X bus request
  output logic [23:0] x_data_out, // X read data
  input ofm_pkg::ofm_bus_s y_bus_in, // Y bus request
  output logic [23:0] y_data_out // Y read data
);
  logic [23:0] pmem [0:63];
  logic [23:0] xmem [0:63];
  logic [23:0] ymem [0:63];
  initial begin
    pm_data_out = 24'h000000;
    x_data_out = 24'h000000;
    y_data_out = 24'h000000;
    for (int i = 0; i < 64; i++) begin
      pmem[i] = 24'h000000;
      xmem[i] = 24'h000000;
      ymem[i] = 24'h000000;
    end
  end
  // Inverting idle data keeps a late sample from passing by luck
  always @(posedge ref_clk_in) begin
    pm_data_out <= pm_rd_in ? pmem[pm_addr_in[5:0]] : ~pm_data_out;
    x_data_out <= x_bus_in.rd ? xmem[x_bus_in.addr[5:0]] : ~x_data_out;
    y_data_out <= y_bus_in.rd ? ymem[y_bus_in.addr[5:0]] : ~y_data_out;
    if (x_bus_in.wr) begin
      xmem[x_bus_in.addr[5:0]] <= x_bus_in.wdata;
    end
    if (y_bus_in.wr) begin
      ymem[y_bus_in.addr[5:0]] <= y_bus_in.wdata;
    end
  end
endmodule

/* ofm_move_datapath.sv */
// Instruction fetch, operand formatting and register moves of the data unit.
// Program memory and both data buses answer a read strobe one cycle later.
`timescale 1ns/100ps
module ofm_move_datapath (
  input wire logic ref_clk_in, // Core clock
  input wire logic nrst_in, // Async reset, active low
  output logic pm_rd_out, // Program memory read strobe
  output logic [23:0] pm_addr_out, // Program memory address
  input wire logic [23:0] pm_data_in, // Program word, cycle after strobe
  output ofm_pkg::ofm_bus_s x_side_data_bus_out, // X bus request
  input wire logic [23:0] x_side_data_bus_in, // X read data
  output ofm_pkg::ofm_bus_s y_side_data_bus_out, // Y bus request
  input wire logic [23:0] y_side_data_bus_in, // Y read data
  input wire logic [7:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  output logic [31:0] reg_rdata_out // Register read data
);
  ofm_pkg::ofm_state_e state_ff, nxt_state;
  logic [9:0][23:0] regs_ff, nxt_regs;
  logic [23:0] op_ff, nxt_op;
  logic [15:0] ext_ff, nxt_ext;
  logic [23:0] pc_ff, nxt_pc;
  logic pm_rd_ff, nxt_pm_rd;
  logic [23:0] pm_addr_ff, nxt_pm_addr;
  logic [7:0] ccr_ff, nxt_ccr;
  logic [7:0] mr_ff;
  logic [7:0] ctrl_ff;
  logic [31:0] rdata_ff;
  ofm_pkg::ofm_bus_s xb_ff, nxt_xb, yb_ff, nxt_yb;

  function automatic logic [23:0] mask16(input logic [23:0] v, input logic six);
    return six ? {v[23:8], 8'h00} : v;
  endfunction

  function automatic logic is_full(input logic [3:0] code);
    return (code == ofm_pkg::ACC_A) || (code == ofm_pkg::ACC_B);
  endfunction

  // Bus selector: 0/1 pick the bus's own data registers, 2/3 the accumulators
  function automatic logic [3:0] sel_code(input logic [1:0] sel, input logic [3:0] r0, input logic [3:0] r1);
    case (sel)
      2'h0: sel_code = r0;
      2'h1: sel_code = r1;
      2'h2: sel_code = ofm_pkg::ACC_A;
      default: sel_code = ofm_pkg::ACC_B;
    endcase
  endfunction

  function automatic logic [23:0] src_word(input logic [3:0] code, input logic [9:0][23:0] r,
                                           input logic [23:0] wa, input logic [23:0] wb);
    if (code == ofm_pkg::ACC_A)
      src_word = wa;
    else if (code == ofm_pkg::ACC_B)
      src_word = wb;
    else if (code == ofm_pkg::R_A2 || code == ofm_pkg::R_B2)
      src_word = {{16{r[code][7]}}, r[code][7:0]};
    else if (code < ofm_pkg::ACC_A)
      src_word = r[code];
    else
      src_word = 24'h000000;
  endfunction

  function automatic logic lim_of(input logic [3:0] code, input logic la, input logic lb);
    return (code == ofm_pkg::ACC_A) ? la : ((code == ofm_pkg::ACC_B) ? lb : 1'b0);
  endfunction

  // New value of register idx after one write port
  function automatic logic [23:0] dst_word(input logic [3:0] idx, input logic [3:0] code,
                                           input logic [23:0] cur, input logic [23:0] val,
                                           input ofm_pkg::ofm_acc_s f, input logic six);
    logic in_a;
    logic in_b;
    in_a = (code == ofm_pkg::ACC_A);
    in_b = (code == ofm_pkg::ACC_B);
    dst_word = cur;
    if (code == idx) begin
      if (idx == ofm_pkg::R_A2 || idx == ofm_pkg::R_B2)
        dst_word = {16'h0000, val[7:0]};
      else
        dst_word = mask16(val, six);
    end else if ((in_a && idx == ofm_pkg::R_A2) || (in_b && idx == ofm_pkg::R_B2)) begin
      dst_word = {16'h0000, f.ext};
    end else if ((in_a && idx == ofm_pkg::R_A1) || (in_b && idx == ofm_pkg::R_B1)) begin
      dst_word = f.mid;
    end else if ((in_a && idx == ofm_pkg::R_A0) || (in_b && idx == ofm_pkg::R_B0)) begin
      dst_word = f.low;
    end
  endfunction

  // Decode of the held operation word
  wire logic six = ctrl_ff[ofm_pkg::CTRL_SIXTEEN_BIT];
  wire logic run = ctrl_ff[ofm_pkg::CTRL_RUN_BIT];
  wire logic [1:0] scale = mr_ff[ofm_pkg::SCALE_LSB +: 2];
  wire logic cond_on = op_ff[ofm_pkg::OP_COND_BIT];
  wire logic [1:0] cc = op_ff[ofm_pkg::OP_CC_LSB +: 2];
  wire logic [3:0] alu_op = op_ff[ofm_pkg::OP_ALU_LSB +: 4];
  wire logic [3:0] src = op_ff[ofm_pkg::OP_SRC_LSB +: 4];
  wire logic [3:0] dst = op_ff[ofm_pkg::OP_DST_LSB +: 4];
  wire logic ccr_z = ccr_ff[ofm_pkg::CCR_Z_BIT];
  wire logic ccr_l = ccr_ff[ofm_pkg::CCR_L_BIT];
  wire logic cond_true = !cond_on || (cc == ofm_pkg::CC_ALWAYS) || (cc == ofm_pkg::CC_ZSET && ccr_z) ||
                         (cc == ofm_pkg::CC_ZCLR && !ccr_z) || (cc == ofm_pkg::CC_LCLR && !ccr_l);
  wire logic alu_go = cond_true && (alu_op != ofm_pkg::ALU_NONE);
  wire logic moves_ok = !cond_on;
  wire logic x_en = moves_ok && op_ff[ofm_pkg::OP_XEN_BIT];
  wire logic x_wr = x_en && op_ff[ofm_pkg::OP_XDIR_BIT];
  wire logic x_rd = x_en && !op_ff[ofm_pkg::OP_XDIR_BIT];
  wire logic y_en = moves_ok && op_ff[ofm_pkg::OP_YEN_BIT];
  wire logic y_wr = y_en && op_ff[ofm_pkg::OP_YDIR_BIT];
  wire logic y_rd = y_en && !op_ff[ofm_pkg::OP_YDIR_BIT];
  wire logic [3:0] x_code = sel_code(op_ff[ofm_pkg::OP_XSEL_LSB +: 2], ofm_pkg::R_X0, ofm_pkg::R_X1);
  wire logic [3:0] y_code = sel_code(op_ff[ofm_pkg::OP_YSEL_LSB +: 2], ofm_pkg::R_Y0, ofm_pkg::R_Y1);
  wire logic is_issue = (state_ff == ofm_pkg::ST_ISSUE);
  wire logic is_wb = (state_ff == ofm_pkg::ST_WB);

  // Source paths of both accumulators
  wire logic [55:0] acc_a = {regs_ff[ofm_pkg::R_A2][7:0], regs_ff[ofm_pkg::R_A1], regs_ff[ofm_pkg::R_A0]};
  wire logic [55:0] acc_b = {regs_ff[ofm_pkg::R_B2][7:0], regs_ff[ofm_pkg::R_B1], regs_ff[ofm_pkg::R_B0]};
  logic [23:0] word_a, word_b;
  logic lim_a, lim_b;

  ofm_acc_read u_read_a (
    .acc_in(acc_a),
    .scale_in(scale),
    .six_in(six),
    .word_out(word_a),
    .lim_out(lim_a)
  );

  ofm_acc_read u_read_b (
    .acc_in(acc_b),
    .scale_in(scale),
    .six_in(six),
    .word_out(word_b),
    .lim_out(lim_b)
  );

  wire logic [23:0] alu_src_val = src_word(src, regs_ff, word_a, word_b);
  wire logic [23:0] x_src_val = src_word(x_code, regs_ff, word_a, word_b);
  wire logic [23:0] y_src_val = src_word(y_code, regs_ff, word_a, word_b);
  wire logic [23:0] imm_val = six ? {ext_ff, 8'h00} : {8'h00, ext_ff};
  wire logic [23:0] alu_val = (alu_op == ofm_pkg::ALU_XFER) ? alu_src_val :
                              (alu_op == ofm_pkg::ALU_IMM) ? imm_val : 24'h000000;

  // Only a 24-bit destination counts a saturated full-accumulator source
  wire logic lim_ev = is_issue && ((alu_go && alu_op == ofm_pkg::ALU_XFER && !is_full(dst) &&
                      lim_of(src, lim_a, lim_b)) || (x_wr && lim_of(x_code, lim_a, lim_b)) ||
                      (y_wr && lim_of(y_code, lim_a, lim_b)));

  // Two write ports: data unit result in issue, bus read data in write-back
  wire logic [3:0] p0_code = is_issue ? (alu_go ? dst : ofm_pkg::R_NONE) :
                             ((is_wb && x_rd) ? x_code : ofm_pkg::R_NONE);
  wire logic [23:0] p0_val = is_issue ? alu_val : x_side_data_bus_in;
  wire logic [3:0] p1_code = (is_wb && y_rd) ? y_code : ofm_pkg::R_NONE;
  ofm_pkg::ofm_acc_s f0, f1;

  ofm_acc_write u_write_0 (
    .src_in(p0_val),
    .six_in(six),
    .acc_out(f0)
  );

  ofm_acc_write u_write_1 (
    .src_in(y_side_data_bus_in),
    .six_in(six),
    .acc_out(f1)
  );

  // Y data wins over X when both land on the same register
  always_comb begin
    for (int i = 0; i < ofm_pkg::NUM_REGS; i++) begin
      nxt_regs[i] = dst_word(4'(i), p1_code, dst_word(4'(i), p0_code, regs_ff[i], p0_val, f0, six),
                             y_side_data_bus_in, f1, six);
    end
  end

  // Register port decode
  wire logic sw_status = reg_wr_in && (reg_addr_in == ofm_pkg::OFS_STATUS);
  wire logic sw_ctrl = reg_wr_in && (reg_addr_in == ofm_pkg::OFS_CTRL);
  wire logic [3:0] rd_idx = reg_addr_in[5:2];
  wire logic rd_reg_hit = (reg_addr_in[7:6] == ofm_pkg::REGS_PAGE) && (reg_addr_in[1:0] == 2'h0) &&
                          (rd_idx < 4'(ofm_pkg::NUM_REGS));
  wire logic [23:0] status_word = {8'h00, mr_ff, ccr_ff};
  wire logic [31:0] rd_mux = (reg_addr_in == ofm_pkg::OFS_STATUS) ? {8'h00, status_word} :
                             (reg_addr_in == ofm_pkg::OFS_CTRL) ? {24'h000000, ctrl_ff} :
                             (reg_addr_in == ofm_pkg::OFS_PC) ? {8'h00, pc_ff} :
                             rd_reg_hit ? {8'h00, regs_ff[rd_idx]} : 32'h00000000;

  // Hardware set of the limit flag wins over a software clear
  always_comb begin
    nxt_ccr = sw_status ? reg_wdata_in[ofm_pkg::CCR_LSB +: 8] : ccr_ff;
    if (is_issue && alu_go)
      nxt_ccr[ofm_pkg::CCR_Z_BIT] = (alu_val == 24'h000000);
    if (lim_ev)
      nxt_ccr[ofm_pkg::CCR_L_BIT] = 1'b1;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_pm_rd = 1'b0;
    nxt_pm_addr = pm_addr_ff;
    nxt_pc = pc_ff;
    nxt_op = op_ff;
    nxt_ext = ext_ff;
    nxt_xb = '0;
    nxt_yb = '0;
    case (state_ff)
      ofm_pkg::ST_IDLE: begin
        if (run) begin
          nxt_pm_rd = 1'b1;
          nxt_pm_addr = pc_ff;
          nxt_pc = pc_ff + 24'h000001;
          nxt_state = ofm_pkg::ST_FET;
        end
      end
      ofm_pkg::ST_FET: nxt_state = ofm_pkg::ST_OPW;
      ofm_pkg::ST_OPW: begin
        nxt_op = pm_data_in;
        nxt_ext = 16'h0000;
        if (pm_data_in[ofm_pkg::OP_EXT_BIT]) begin
          nxt_pm_rd = 1'b1;
          nxt_pm_addr = pc_ff;
          nxt_pc = pc_ff + 24'h000001;
          nxt_state = ofm_pkg::ST_EXTF;
        end else begin
          nxt_state = ofm_pkg::ST_ISSUE;
        end
      end
      ofm_pkg::ST_EXTF: nxt_state = ofm_pkg::ST_EXTW;
      ofm_pkg::ST_EXTW: begin
        nxt_ext = pm_data_in[15:0];
        nxt_state = ofm_pkg::ST_ISSUE;
      end
      ofm_pkg::ST_ISSUE: begin
        nxt_xb.rd = x_rd;
        nxt_xb.wr = x_wr;
        nxt_xb.addr = ext_ff;
        nxt_xb.wdata = x_src_val;
        nxt_yb.rd = y_rd;
        nxt_yb.wr = y_wr;
        nxt_yb.addr = ext_ff;
        nxt_yb.wdata = y_src_val;
        nxt_state = ofm_pkg::ST_EXEC;
      end
      ofm_pkg::ST_EXEC: begin
        // Next operation word is prefetched while bus data returns
        if (run) begin
          nxt_pm_rd = 1'b1;
          nxt_pm_addr = pc_ff;
          nxt_pc = pc_ff + 24'h000001;
        end
        nxt_state = ofm_pkg::ST_WB;
      end
      ofm_pkg::ST_WB: nxt_state = pm_rd_ff ? ofm_pkg::ST_OPW : ofm_pkg::ST_IDLE;
      default: nxt_state = ofm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= ofm_pkg::ST_IDLE;
      regs_ff <= '0;
      op_ff <= 24'h000000;
      ext_ff <= 16'h0000;
      pc_ff <= ofm_pkg::PC_RST;
      pm_rd_ff <= 1'b0;
      pm_addr_ff <= ofm_pkg::PC_RST;
      xb_ff <= '0;
      yb_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      regs_ff <= nxt_regs;
      op_ff <= nxt_op;
      ext_ff <= nxt_ext;
      pc_ff <= nxt_pc;
      pm_rd_ff <= nxt_pm_rd;
      pm_addr_ff <= nxt_pm_addr;
      xb_ff <= nxt_xb;
      yb_ff <= nxt_yb;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ccr_ff <= ofm_pkg::CCR_RST;
      mr_ff <= ofm_pkg::MR_RST;
      ctrl_ff <= ofm_pkg::CTRL_RST;
      rdata_ff <= 32'h00000000;
    end else begin
      ccr_ff <= nxt_ccr;
      mr_ff <= sw_status ? reg_wdata_in[ofm_pkg::MR_LSB +: 8] : mr_ff;
      ctrl_ff <= sw_ctrl ? reg_wdata_in[7:0] : ctrl_ff;
      rdata_ff <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  assign pm_rd_out = pm_rd_ff;
  assign pm_addr_out = pm_addr_ff;
  assign x_side_data_bus_out = xb_ff;
  assign y_side_data_bus_out = yb_ff;
  assign reg_rdata_out = rdata_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_ext_low_half: assert property ((state_ff == ofm_pkg::ST_EXTW) |=>
    (ext_ff == $past(pm_data_in[15:0]))) else $error("extension word not cut to 16 bits");
  a_pc_skips_ext: assert property ((state_ff == ofm_pkg::ST_OPW && pm_data_in[ofm_pkg::OP_EXT_BIT]) |=>
    (pm_rd_out && pc_ff == pm_addr_out + 24'h000001) ##2 (state_ff == ofm_pkg::ST_ISSUE))
    else $error("extension fetch or pc advance wrong");
  a_cond_no_move: assert property ((is_issue && cond_on) |=>
    !(x_side_data_bus_out.rd || x_side_data_bus_out.wr || y_side_data_bus_out.rd || y_side_data_bus_out.wr))
    else $error("conditional instruction moved data");
  a_limit_latched: assert property ((ccr_l && !sw_status) |=> ccr_l)
    else $error("limit flag dropped without software write");
  a_ext_sign_fill: assert property ((is_issue && alu_go && alu_op == ofm_pkg::ALU_XFER &&
    src == ofm_pkg::R_A2 && dst == ofm_pkg::R_X1 && !six) |=>
    (regs_ff[ofm_pkg::R_X1] == {{16{$past(regs_ff[ofm_pkg::R_A2][7])}}, $past(regs_ff[ofm_pkg::R_A2][7:0])}))
    else $error("extension source not sign filled");
  a_acc_fill: assert property ((p0_code == ofm_pkg::ACC_A && p1_code != ofm_pkg::ACC_A && !six) |=>
    (regs_ff[ofm_pkg::R_A0] == 24'h000000 && regs_ff[ofm_pkg::R_A2][7:0] == {8{regs_ff[ofm_pkg::R_A1][23]}}))
    else $error("accumulator load not sign extended and zero filled");
  a_middle_only: assert property ((p0_code == ofm_pkg::R_A1 && p1_code == ofm_pkg::R_NONE) |=>
    ($stable(regs_ff[ofm_pkg::R_A0]) && $stable(regs_ff[ofm_pkg::R_A2]))) else $error("middle write touched other parts");
  a_sat_value: assert property ((is_issue && x_wr && x_code == ofm_pkg::ACC_A && lim_a) |=>
    (x_side_data_bus_out.wdata == ($past(acc_a[55]) ? ofm_pkg::SAT_NEG : ofm_pkg::SAT_POS) && ccr_l))
    else $error("saturation value or flag wrong");
  a_exec_flow: assert property ((state_ff == ofm_pkg::ST_EXEC && run) |->
    ##1 (is_wb && pm_rd_out) ##1 (state_ff == ofm_pkg::ST_OPW)) else $error("prefetch not overlapped");
endmodule

/* ofm_pkg.sv */
// Constants, types and field layouts shared by the operand move datapath.
// Assumes a single core clock; all users refer to names as ofm_pkg::name.
package ofm_pkg;
  localparam int WORD_W = 24;
  localparam int ACC_W = 56;
  localparam int EXT_ADDR_W = 16;
  localparam int NUM_REGS = 10;
  // Operation word fields (bit positions)
  localparam int OP_EXT_BIT = 23;
  localparam int OP_COND_BIT = 22;
  localparam int OP_CC_LSB = 20;
  localparam int OP_ALU_LSB = 16;
  localparam int OP_SRC_LSB = 12;
  localparam int OP_DST_LSB = 8;
  localparam int OP_XEN_BIT = 7;
  localparam int OP_XDIR_BIT = 6;
  localparam int OP_XSEL_LSB = 4;
  localparam int OP_YEN_BIT = 3;
  localparam int OP_YDIR_BIT = 2;
  localparam int OP_YSEL_LSB = 0;
  // Register codes
  localparam logic [3:0] R_X0 = 4'h0;
  localparam logic [3:0] R_X1 = 4'h1;
  localparam logic [3:0] R_Y0 = 4'h2;
  localparam logic [3:0] R_Y1 = 4'h3;
  localparam logic [3:0] R_A0 = 4'h4;
  localparam logic [3:0] R_A1 = 4'h5;
  localparam logic [3:0] R_A2 = 4'h6;
  localparam logic [3:0] R_B0 = 4'h7;
  localparam logic [3:0] R_B1 = 4'h8;
  localparam logic [3:0] R_B2 = 4'h9;
  localparam logic [3:0] ACC_A = 4'hA;
  localparam logic [3:0] ACC_B = 4'hB;
  localparam logic [3:0] R_NONE = 4'hF;
  // Data unit operations
  localparam logic [3:0] ALU_NONE = 4'h0;
  localparam logic [3:0] ALU_XFER = 4'h1;
  localparam logic [3:0] ALU_CLR = 4'h2;
  localparam logic [3:0] ALU_IMM = 4'h3;
  // Condition codes
  localparam logic [1:0] CC_ALWAYS = 2'h0;
  localparam logic [1:0] CC_ZSET = 2'h1;
  localparam logic [1:0] CC_ZCLR = 2'h2;
  localparam logic [1:0] CC_LCLR = 2'h3;
  // Scaling modes
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP = 2'h2;
  localparam logic [23:0] SAT_POS = 24'h7FFFFF;
  localparam logic [23:0] SAT_NEG = 24'h800000;
  // Status word layout and flag positions
  localparam int CCR_LSB = 0;
  localparam int MR_LSB = 8;
  localparam int CCR_Z_BIT = 2;
  localparam int CCR_L_BIT = 6;
  localparam int SCALE_LSB = 0;
  localparam int CTRL_SIXTEEN_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  // Register port map
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [1:0] REGS_PAGE = 2'h1;
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] MR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [23:0] PC_RST = 24'h000000;

  typedef struct packed {
    logic [7:0] ext;
    logic [23:0] mid;
    logic [23:0] low;
  } ofm_acc_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [23:0] wdata;
  } ofm_bus_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FET = 3'b001,
    ST_OPW = 3'b010,
    ST_EXTF = 3'b011,
    ST_EXTW = 3'b100,
    ST_ISSUE = 3'b101,
    ST_EXEC = 3'b110,
    ST_WB = 3'b111
  } ofm_state_e;
endpackage

/* tb.sv */
// Self-checking bench for the operand move datapath.
// Runs two short programs from the memory model, inspecting registers after each.
`timescale 1ns/100ps
module tb;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h00000000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic pm_rd;
  logic [23:0] pm_addr, pm_data, x_rd_data, y_rd_data;
  ofm_pkg::ofm_bus_s x_req, y_req;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] rd_val;

  ofm_move_datapath ofm_move_datapath_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .pm_rd_out(pm_rd),
    .pm_addr_out(pm_addr), .pm_data_in(pm_data), .x_side_data_bus_out(x_req), .x_side_data_bus_in(x_rd_data),
    .y_side_data_bus_out(y_req), .y_side_data_bus_in(y_rd_data), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
  ofm_mem_model ofm_mem_model_inst (.ref_clk_in(ref_clk_in), .pm_rd_in(pm_rd), .pm_addr_in(pm_addr),
    .pm_data_out(pm_data), .x_bus_in(x_req), .x_data_out(x_rd_data), .y_bus_in(y_req), .y_data_out(y_rd_data));

  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    reg_read(a, rd_val);
    check(rd_val & mask, exp, "register read");
  endtask

  // Lets the core run until the program counter reaches stop, then halts it
  task automatic run_prog(input logic [31:0] ctrl, input logic [31:0] stop);
    reg_write(ofm_pkg::OFS_CTRL, ctrl);
    for (int i = 0; i < 100; i++) begin
      reg_read(ofm_pkg::OFS_PC, rd_val);
      if (rd_val >= stop) begin
        break;
      end
    end
    check({31'h0, rd_val >= stop}, 32'h00000001, "program ran to end");
    reg_write(ofm_pkg::OFS_CTRL, 32'h00000000);
    repeat (8) @(posedge ref_clk_in);
  endtask

  function automatic logic [23:0] opw(input logic e, input logic c, input logic [1:0] cc,
      input logic [3:0] alu, input logic [3:0] s, input logic [3:0] d, input logic [3:0] xm, input logic [3:0] ym);
    return {e, c, cc, alu, s, d, xm, ym};
  endfunction

  task automatic test_reset_values();
    read_check(ofm_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h00000000);
    read_check(ofm_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
    read_check(ofm_pkg::OFS_PC, 32'hFFFFFFFF, 32'h00000000);
    reg_write(8'h30, 32'h00FFFFFF);
    read_check(8'h30, 32'hFFFFFFFF, 32'h00000000);
  endtask

  // Moves, extension handling, limiting and a suppressed conditional op
  task automatic test_program();
    ofm_mem_model_inst.xmem[16] = 24'h800001;
    ofm_mem_model_inst.ymem[16] = 24'h654321;
    ofm_mem_model_inst.pmem[0] = opw(1'b1, 1'b0, 2'h0, ofm_pkg::ALU_NONE, ofm_pkg::R_NONE, ofm_pkg::R_NONE, 4'h8, 4'h9);
    ofm_mem_model_inst.pmem[1] = 24'hAB0010;
    ofm_mem_model_inst.pmem[2] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::R_X0, ofm_pkg::ACC_A, 4'h0, 4'h0);
    ofm_mem_model_inst.pmem[3] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::R_A2, ofm_pkg::R_X1, 4'h0, 4'h0);
    ofm_mem_model_inst.pmem[4] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::R_X0, ofm_pkg::R_A2, 4'h0, 4'h0);
    ofm_mem_model_inst.pmem[5] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::ACC_A, ofm_pkg::R_Y0, 4'h0, 4'h0);
    ofm_mem_model_inst.pmem[6] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::R_A1, ofm_pkg::R_Y1, 4'h0, 4'h0);
    ofm_mem_model_inst.pmem[7] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::R_X1, ofm_pkg::R_A1, 4'h0, 4'h0);
    ofm_mem_model_inst.pmem[8] = opw(1'b0, 1'b1, ofm_pkg::CC_LCLR, ofm_pkg::ALU_XFER, ofm_pkg::R_X1, ofm_pkg::R_X0,
      4'hD, 4'h0);
    ofm_mem_model_inst.pmem[9] = opw(1'b1, 1'b0, 2'h0, ofm_pkg::ALU_NONE, ofm_pkg::R_NONE, ofm_pkg::R_NONE, 4'hD, 4'hC);
    ofm_mem_model_inst.pmem[10] = 24'hCD0020;
    run_prog(32'h00000002, 32'd14);
    read_check(8'h40, 32'hFFFFFFFF, 32'h00800001);
    read_check(8'h44, 32'hFFFFFFFF, 32'h00FFFFFF);
    read_check(8'h48, 32'hFFFFFFFF, 32'h007FFFFF);
    read_check(8'h4C, 32'hFFFFFFFF, 32'h00800001);
    read_check(8'h50, 32'hFFFFFFFF, 32'h00000000);
    read_check(8'h54, 32'hFFFFFFFF, 32'h00FFFFFF);
    read_check(8'h58, 32'hFFFFFFFF, 32'h00000001);
    read_check(ofm_pkg::OFS_STATUS, 32'h00000040, 32'h00000040);
    check({8'h00, ofm_mem_model_inst.xmem[0]}, 32'h00000000, "suppressed move");
    check({8'h00, ofm_mem_model_inst.xmem[32]}, 32'h00FFFFFF, "x write");
    check({8'h00, ofm_mem_model_inst.ymem[32]}, 32'h007FFFFF, "y write");
    reg_write(ofm_pkg::OFS_STATUS, 32'h00000000);
    read_check(ofm_pkg::OFS_STATUS, 32'h00000040, 32'h00000000);
  endtask

  // Sixteen-bit mode with scale-down: immediate, clear, Z conditions, limited bus write
  task automatic test_modes();
    logic [31:0] base;
    logic [23:0] prog [0:7];
    prog[0] = opw(1'b1, 1'b0, 2'h0, ofm_pkg::ALU_IMM, ofm_pkg::R_NONE, ofm_pkg::ACC_B, 4'h0, 4'h0);
    prog[1] = 24'hFF8123;
    prog[2] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_XFER, ofm_pkg::ACC_B, ofm_pkg::R_X0, 4'h0, 4'h0);
    prog[3] = opw(1'b0, 1'b0, 2'h0, ofm_pkg::ALU_CLR, ofm_pkg::R_NONE, ofm_pkg::R_B1, 4'h0, 4'h0);
    prog[4] = opw(1'b0, 1'b1, ofm_pkg::CC_ZCLR, ofm_pkg::ALU_XFER, ofm_pkg::R_X0, ofm_pkg::R_Y0, 4'h0, 4'h0);
    prog[5] = opw(1'b0, 1'b1, ofm_pkg::CC_ZSET, ofm_pkg::ALU_XFER, ofm_pkg::R_X0, ofm_pkg::R_Y1, 4'h0, 4'h0);
    prog[6] = opw(1'b1, 1'b0, 2'h0, ofm_pkg::ALU_NONE, ofm_pkg::R_NONE, ofm_pkg::R_NONE, 4'hE, 4'h0);
    prog[7] = 24'h000030;
    reg_read(ofm_pkg::OFS_PC, base);
    for (int i = 0; i < 8; i++) begin
      ofm_mem_model_inst.pmem[6'(base + 32'(i))] = prog[i];
    end
    reg_write(ofm_pkg::OFS_STATUS, 32'h00000100);
    run_prog(32'h00000003, base + 32'd10);
    read_check(8'h40, 32'hFFFFFFFF, 32'h00C09100);
    read_check(8'h48, 32'hFFFFFFFF, 32'h007FFFFF);
    read_check(8'h4C, 32'hFFFFFFFF, 32'h00C09100);
    read_check(8'h5C, 32'hFFFFFFFF, 32'h00000000);
    read_check(8'h60, 32'hFFFFFFFF, 32'h00000000);
    read_check(8'h64, 32'hFFFFFFFF, 32'h000000FF);
    read_check(ofm_pkg::OFS_STATUS, 32'h0000FF44, 32'h00000140);
    check({8'h00, ofm_mem_model_inst.xmem[48]}, 32'h007FFFFF, "limited x write");
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    test_reset_values();
    test_program();
    test_modes();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    fail_count++;
    print_verdict();
  end
endmodule
